//--- inc/chc_defs.vh
// constants for the charger configuration and current register bank
`ifndef CHC_DEFS_VH
`define CHC_DEFS_VH

// serial slave address and register space
`define CHC_SLAVE_ADDR       7'h6B
`define CHC_NUM_REGS         4'h8
`define CHC_IDX_INPUT_SRC    3'h0
`define CHC_IDX_POWER_ON_CFG 3'h1
`define CHC_IDX_CHG_CURRENT  3'h2
`define CHC_IDX_PRECHG_TERM  3'h3
`define CHC_IDX_CHG_VOLTAGE  3'h4
`define CHC_IDX_TERM_TIMER   3'h5
`define CHC_IDX_IR_THERMAL   3'h6
`define CHC_IDX_MISC         3'h7

// reset values
`define CHC_RST_INPUT_SRC    8'h3D
`define CHC_RST_POWER_ON_CFG 8'h1B
`define CHC_RST_CHG_CURRENT  8'h20
`define CHC_RST_PRECHG_TERM  8'h11
`define CHC_RST_CHG_VOLTAGE  8'h9A
`define CHC_RST_TERM_TIMER   8'h9A
`define CHC_RST_IR_THERMAL   8'h03
`define CHC_RST_MISC         8'h4B

// power-on configuration fields
`define CHC_POC_REG_RESET    7
`define CHC_POC_WD_RESTART   6
`define CHC_POC_MODE_HI      5
`define CHC_POC_MODE_LO      4
`define CHC_POC_SYSMIN_HI    3
`define CHC_POC_SYSMIN_LO    1
`define CHC_POC_BOOST_SEL    0
`define CHC_POC_STORE_MASK   8'h3F

// charge current control fields
`define CHC_CCC_FAST_HI      7
`define CHC_CCC_FAST_LO      2
`define CHC_CCC_RESERVED     1
`define CHC_CCC_FORCE        0
`define CHC_CCC_STORE_MASK   8'hFD

// precharge field inside the precharge/termination register
`define CHC_PTC_PRE_HI       7
`define CHC_PTC_PRE_LO       4

// mode select encodings
`define CHC_MODE_DISABLE     2'h0
`define CHC_MODE_CHARGE      2'h1

// analog scaling, in millivolts and milliamps
`define CHC_SYSMIN_OFFSET_MV 13'h0BB8
`define CHC_SYSMIN_STEP_MV   13'h0064
`define CHC_BOOST_LO_MA      11'h1F4
`define CHC_BOOST_HI_MA      11'h514
`define CHC_FAST_OFFSET_MA   13'h0200
`define CHC_FAST_STEP_MA     13'h0040
`define CHC_PRE_OFFSET_MA    13'h0080
`define CHC_PRE_STEP_MA      13'h0080
`define CHC_FORCE_FAST_DIV   13'h0005
`define CHC_FORCE_PRE_SHIFT  1

`endif

//--- rtl/chc_serial_slave.v
// two-wire serial slave: byte framing, address match, register pointer
`timescale 1ns/1ns
`include "chc_defs.vh"

module chc_serial_slave (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       rstn_in,
  // serial pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe_n_out,
  // register side
  output reg        wr_en_out,
  output reg  [2:0] wr_addr_out,
  output reg  [7:0] wr_data_out,
  output wire [2:0] rd_addr_out,
  input  wire [7:0] rd_data_in
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RX   = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_TX   = 3'h3;
  localparam ST_MACK = 3'h4;

  localparam KIND_DEV  = 2'h0;
  localparam KIND_REG  = 2'h1;
  localparam KIND_DATA = 2'h2;

  reg  [2:0] scl_sync;
  reg  [2:0] sda_sync;
  reg        scl_f;
  reg        sda_f;
  reg        scl_prev;
  reg        sda_prev;
  reg  [2:0] state;
  reg  [3:0] cnt;
  reg  [7:0] shreg;
  reg  [1:0] kind;
  reg        rw;
  reg  [3:0] ptr;
  reg        mack;

  wire scl_rise = scl_f & ~scl_prev;
  wire scl_fall = ~scl_f & scl_prev;
  wire start_c  = scl_f & scl_prev & sda_prev & ~sda_f;
  wire stop_c   = scl_f & scl_prev & ~sda_prev & sda_f;

  // index inside the implemented register window
  function in_window;
    input [3:0] idx;
    begin
      in_window = (idx < `CHC_NUM_REGS);
    end
  endfunction

  assign rd_addr_out = ptr[2:0];

  // three-stage pin capture; a level counts once stages two and three agree
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  // byte state machine; sda only changes while scl is low
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state        <= ST_IDLE;
      cnt          <= 4'h0;
      shreg        <= 8'h00;
      kind         <= KIND_DEV;
      rw           <= 1'b0;
      ptr          <= 4'h0;
      mack         <= 1'b1;
      sda_oe_n_out <= 1'b1;
      wr_en_out    <= 1'b0;
      wr_addr_out  <= 3'h0;
      wr_data_out  <= 8'h00;
    end else begin
      wr_en_out <= 1'b0;
      if (start_c) begin
        state        <= ST_RX;
        cnt          <= 4'h0;
        kind         <= KIND_DEV;
        sda_oe_n_out <= 1'b1;
      end else if (stop_c) begin
        state        <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_f};
              cnt   <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              state        <= ST_ACK;
              sda_oe_n_out <= 1'b0;
              case (kind)
                KIND_DEV: begin
                  // other addresses are left unanswered
                  if (shreg[7:1] == `CHC_SLAVE_ADDR) begin
                    rw <= shreg[0];
                  end else begin
                    state        <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                  end
                end
                KIND_REG: begin
                  // undefined register index answers with a nack
                  if (in_window(shreg[3:0]) && shreg[7:4] == 4'h0) begin
                    ptr <= shreg[3:0];
                  end else begin
                    state        <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                  end
                end
                default: begin
                  if (in_window(ptr)) begin
                    wr_en_out   <= 1'b1;
                    wr_addr_out <= ptr[2:0];
                    wr_data_out <= shreg;
                    ptr         <= ptr + 4'h1;
                  end else begin
                    state        <= ST_IDLE;
                    sda_oe_n_out <= 1'b1;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw && kind == KIND_DEV) begin
                // reads past the window return zero; a zero bit is a pulled-low line
                state        <= ST_TX;
                sda_oe_n_out <= in_window(ptr) ? rd_data_in[7] : 1'b0;
                shreg        <= in_window(ptr) ? {rd_data_in[6:0], 1'b0} : 8'h00;
              end else begin
                state        <= ST_RX;
                sda_oe_n_out <= 1'b1;
                kind         <= (kind == KIND_DEV) ? KIND_REG : KIND_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == 4'h8) begin
                state        <= ST_MACK;
                sda_oe_n_out <= 1'b1;
                ptr          <= in_window(ptr) ? ptr + 4'h1 : ptr;
              end else begin
                sda_oe_n_out <= shreg[7];
                shreg        <= {shreg[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack <= sda_f;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (!mack) begin
                state        <= ST_TX;
                sda_oe_n_out <= in_window(ptr) ? rd_data_in[7] : 1'b0;
                shreg        <= in_window(ptr) ? {rd_data_in[6:0], 1'b0} : 8'h00;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state        <= ST_IDLE;
            sda_oe_n_out <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

//--- rtl/chc_config_regs.v
// charger configuration and charge current register bank behind the serial slave
// Notes on behaviour
// - writing one to bit 7 of the power-on configuration register restores every register to its reset value and the bit reads back zero.
// - writing one to bit 6 of the power-on configuration register restarts the host watchdog and the bit clears itself.
// - the mode select decodes 00 as charge off, 01 as charge, 10 and 11 as boost, and resets to 01.
// - the minimum system voltage is 3.0 V plus 0.4, 0.2 and 0.1 V weights and resets to code 101.
// - the fast-charge current is 512 mA plus weights from 64 mA to 2048 mA and resets to 001000.
// - with the force bit set the fast-charge current is cut to 20 percent and the precharge current to 50 percent.
// - the charge current register resets to 00100000 and its reserved bit 1 stays zero.
// - the registers answer at serial address 6BH and indices 00 to 07 are readable and writable.
`timescale 1ns/1ns
`include "chc_defs.vh"

module chc_config_regs (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rstn_in,
  // serial pins, open drain data
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n_out,
  // watchdog control
  output reg         watchdog_restart_out,
  // decoded operating settings
  output reg  [1:0]  charge_mode_select_out,
  output reg         charge_enable_out,
  output reg         boost_enable_out,
  output reg  [2:0]  min_system_voltage_out,
  output reg  [12:0] min_system_voltage_mv_out,
  output reg  [10:0] boost_current_limit_ma_out,
  output reg  [5:0]  fast_charge_current_out,
  output reg         reduced_current_force_out,
  output reg  [12:0] fast_charge_current_ma_out,
  output reg  [12:0] precharge_current_ma_out,
  // raw register images for the other regulation loops
  output reg  [7:0]  input_source_control_out,
  output reg  [7:0]  precharge_termination_control_out,
  output reg  [7:0]  charge_voltage_control_out,
  output reg  [7:0]  term_timer_control_out,
  output reg  [7:0]  ir_thermal_control_out,
  output reg  [7:0]  misc_operation_control_out
);

  reg  [7:0] regs [0:7];
  reg        sda_low;
  wire       wr_en;
  wire [2:0] wr_addr;
  wire [7:0] wr_data;
  wire [2:0] rd_addr;
  wire [7:0] rd_data;
  integer    i;

  // reset value of each register index
  function [7:0] reset_value;
    input [2:0] idx;
    begin
      case (idx)
        `CHC_IDX_INPUT_SRC:    reset_value = `CHC_RST_INPUT_SRC;
        `CHC_IDX_POWER_ON_CFG: reset_value = `CHC_RST_POWER_ON_CFG;
        `CHC_IDX_CHG_CURRENT:  reset_value = `CHC_RST_CHG_CURRENT;
        `CHC_IDX_PRECHG_TERM:  reset_value = `CHC_RST_PRECHG_TERM;
        `CHC_IDX_CHG_VOLTAGE:  reset_value = `CHC_RST_CHG_VOLTAGE;
        `CHC_IDX_TERM_TIMER:   reset_value = `CHC_RST_TERM_TIMER;
        `CHC_IDX_IR_THERMAL:   reset_value = `CHC_RST_IR_THERMAL;
        default:               reset_value = `CHC_RST_MISC;
      endcase
    end
  endfunction

  // milliamp value of a fast-charge code
  function [12:0] fast_scale;
    input [5:0] code;
    begin
      fast_scale = `CHC_FAST_OFFSET_MA + `CHC_FAST_STEP_MA * {7'h00, code};
    end
  endfunction

  // milliamp value of a precharge code
  function [12:0] pre_scale;
    input [3:0] code;
    begin
      pre_scale = `CHC_PRE_OFFSET_MA + `CHC_PRE_STEP_MA * {9'h000, code};
    end
  endfunction

  chc_serial_slave u_slave (
    .ref_clk_in   (ref_clk_in),
    .rstn_in      (rstn_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_oe_n_out (sda_oe_n_out),
    .wr_en_out    (wr_en),
    .wr_addr_out  (wr_addr),
    .wr_data_out  (wr_data),
    .rd_addr_out  (rd_addr),
    .rd_data_in   (rd_data)
  );

  // self-clearing bits are never stored, so reads always return zero
  assign rd_data = regs[rd_addr];
  assign sda_out = sda_low;

  // register writes; the reset request wins over the stored fields of the same byte, but a restart bit in it still pulses
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        regs[i] <= reset_value(i[2:0]);
      end
      watchdog_restart_out <= 1'b0;
      sda_low              <= 1'b0;
    end else begin
      sda_low              <= 1'b0;
      watchdog_restart_out <= 1'b0;
      if (wr_en) begin
        if (wr_addr == `CHC_IDX_POWER_ON_CFG) begin
          if (wr_data[`CHC_POC_WD_RESTART]) begin
            watchdog_restart_out <= 1'b1;
          end
          if (wr_data[`CHC_POC_REG_RESET]) begin
            for (i = 0; i < 8; i = i + 1) begin
              regs[i] <= reset_value(i[2:0]);
            end
          end else begin
            regs[wr_addr] <= wr_data & `CHC_POC_STORE_MASK;
          end
        end else if (wr_addr == `CHC_IDX_CHG_CURRENT) begin
          regs[wr_addr] <= wr_data & `CHC_CCC_STORE_MASK;
        end else begin
          regs[wr_addr] <= wr_data;
        end
      end
    end
  end

  // decode fields into operating values, registered so every output is a flop
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      charge_mode_select_out            <= 2'h0;
      charge_enable_out                 <= 1'b0;
      boost_enable_out                  <= 1'b0;
      min_system_voltage_out            <= 3'h0;
      min_system_voltage_mv_out         <= 13'h0000;
      boost_current_limit_ma_out        <= 11'h000;
      fast_charge_current_out           <= 6'h00;
      reduced_current_force_out         <= 1'b0;
      fast_charge_current_ma_out        <= 13'h0000;
      precharge_current_ma_out          <= 13'h0000;
      input_source_control_out          <= 8'h00;
      precharge_termination_control_out <= 8'h00;
      charge_voltage_control_out        <= 8'h00;
      term_timer_control_out            <= 8'h00;
      ir_thermal_control_out            <= 8'h00;
      misc_operation_control_out        <= 8'h00;
    end else begin
      charge_mode_select_out <=
        regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_MODE_HI:`CHC_POC_MODE_LO];
      charge_enable_out <= (regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_MODE_HI:`CHC_POC_MODE_LO]
                            == `CHC_MODE_CHARGE);
      boost_enable_out  <= regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_MODE_HI];
      min_system_voltage_out <=
        regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_SYSMIN_HI:`CHC_POC_SYSMIN_LO];
      min_system_voltage_mv_out <= `CHC_SYSMIN_OFFSET_MV + `CHC_SYSMIN_STEP_MV *
        {10'h000, regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_SYSMIN_HI:`CHC_POC_SYSMIN_LO]};
      boost_current_limit_ma_out <= regs[`CHC_IDX_POWER_ON_CFG][`CHC_POC_BOOST_SEL] ?
        `CHC_BOOST_HI_MA : `CHC_BOOST_LO_MA;
      fast_charge_current_out <=
        regs[`CHC_IDX_CHG_CURRENT][`CHC_CCC_FAST_HI:`CHC_CCC_FAST_LO];
      reduced_current_force_out <= regs[`CHC_IDX_CHG_CURRENT][`CHC_CCC_FORCE];
      // the divide by five is a constant divider; area traded for exact scaling
      if (regs[`CHC_IDX_CHG_CURRENT][`CHC_CCC_FORCE]) begin
        fast_charge_current_ma_out <=
          fast_scale(regs[`CHC_IDX_CHG_CURRENT][`CHC_CCC_FAST_HI:`CHC_CCC_FAST_LO])
          / `CHC_FORCE_FAST_DIV;
        precharge_current_ma_out <=
          pre_scale(regs[`CHC_IDX_PRECHG_TERM][`CHC_PTC_PRE_HI:`CHC_PTC_PRE_LO])
          >> `CHC_FORCE_PRE_SHIFT;
      end else begin
        fast_charge_current_ma_out <=
          fast_scale(regs[`CHC_IDX_CHG_CURRENT][`CHC_CCC_FAST_HI:`CHC_CCC_FAST_LO]);
        precharge_current_ma_out <=
          pre_scale(regs[`CHC_IDX_PRECHG_TERM][`CHC_PTC_PRE_HI:`CHC_PTC_PRE_LO]);
      end
      input_source_control_out          <= regs[`CHC_IDX_INPUT_SRC];
      precharge_termination_control_out <= regs[`CHC_IDX_PRECHG_TERM];
      charge_voltage_control_out        <= regs[`CHC_IDX_CHG_VOLTAGE];
      term_timer_control_out            <= regs[`CHC_IDX_TERM_TIMER];
      ir_thermal_control_out            <= regs[`CHC_IDX_IR_THERMAL];
      misc_operation_control_out        <= regs[`CHC_IDX_MISC];
    end
  end

endmodule

//--- verif/chc_regs_chk_assertions.sv
// port checker for the charger configuration register bank
`timescale 1ns/1ns
module chc_regs_chk (
  // clock and reset
  input wire        ref_clk_in,
  input wire        rstn_in,
  // serial pins
  input wire        scl_in,
  input wire        sda_out,
  input wire        sda_oe_n_out,
  // decoded settings
  input wire        watchdog_restart_out,
  input wire [1:0]  charge_mode_select_out,
  input wire        charge_enable_out,
  input wire        boost_enable_out,
  input wire [2:0]  min_system_voltage_out,
  input wire [12:0] min_system_voltage_mv_out,
  input wire [10:0] boost_current_limit_ma_out,
  input wire [5:0]  fast_charge_current_out,
  input wire        reduced_current_force_out,
  input wire [12:0] fast_charge_current_ma_out,
  input wire [12:0] precharge_current_ma_out,
  input wire [7:0]  precharge_termination_control_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // scaled outputs are only compared once the first decode after reset has landed
  wd_pulse_one_a: assert property (watchdog_restart_out |=> !watchdog_restart_out)
    else $error("restart pulse longer than one cycle");
  chg_en_dec_a: assert property (charge_enable_out == (charge_mode_select_out == 2'h1))
    else $error("charge enable decode wrong");
  boost_en_dec_a: assert property (boost_enable_out == charge_mode_select_out[1])
    else $error("boost enable decode wrong");
  sysmin_scale_a: assert property ($past(rstn_in) |->
    min_system_voltage_mv_out == 13'h0BB8 + 13'h0064 * min_system_voltage_out)
    else $error("minimum system voltage scale wrong");
  fast_plain_a: assert property ($past(rstn_in) && !reduced_current_force_out |->
    fast_charge_current_ma_out == 13'h0200 + 13'h0040 * fast_charge_current_out)
    else $error("fast charge scale wrong");
  fast_force_a: assert property (reduced_current_force_out |->
    fast_charge_current_ma_out == (13'h0200 + 13'h0040 * fast_charge_current_out) / 13'h0005)
    else $error("forced fast charge cut wrong");
  pre_scale_a: assert property ($past(rstn_in) |-> precharge_current_ma_out ==
    (13'h0080 + 13'h0080 * precharge_termination_control_out[7:4]) >> reduced_current_force_out)
    else $error("precharge scale wrong");
  sda_level_a: assert property (sda_out == 1'b0)
    else $error("open drain data drives high");
  ack_edge_a: assert property ($changed(sda_oe_n_out) |->
    scl_in == 1'b0 && $past(scl_in, 3) == 1'b0)
    else $error("data pin moved while clock high");
  rst_decode_a: assert property ($rose(rstn_in) |=> charge_mode_select_out == 2'h1 &&
    min_system_voltage_out == 3'h5 && boost_current_limit_ma_out == 11'h514 &&
    fast_charge_current_out == 6'h08)
    else $error("reset decode wrong");
endmodule

bind chc_config_regs chc_regs_chk u_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .watchdog_restart_out(watchdog_restart_out),
  .charge_mode_select_out(charge_mode_select_out), .charge_enable_out(charge_enable_out),
  .boost_enable_out(boost_enable_out), .min_system_voltage_out(min_system_voltage_out),
  .min_system_voltage_mv_out(min_system_voltage_mv_out),
  .boost_current_limit_ma_out(boost_current_limit_ma_out),
  .fast_charge_current_out(fast_charge_current_out),
  .reduced_current_force_out(reduced_current_force_out),
  .fast_charge_current_ma_out(fast_charge_current_ma_out),
  .precharge_current_ma_out(precharge_current_ma_out),
  .precharge_termination_control_out(precharge_termination_control_out));

//--- verif/chc_host_model.sv
// two-wire host master model facing the register bank
`timescale 1ns/1ns
module chc_host_model (
  // clock and resolved data line
  input  wire ref_clk_in,
  input  wire sda_in,
  // driven pins
  output reg  scl_out,
  output reg  sda_pull_out
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // ten clocks per phase, above the four the slave filter needs
  task step(input c, input p);
    begin
      @(posedge ref_clk_in);
      scl_out <= c;
      sda_pull_out <= p;
      repeat (9) @(posedge ref_clk_in);
    end
  endtask

  // start and repeated start: data falls while clock is high
  task start;
    begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
    end
  endtask

  task stop;
    begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
    end
  endtask

  // one bit out, or one bit sampled late in the high phase when it is settled
  task bit_io(input b, output r);
    begin
      step(1'b0, !b);
      step(1'b1, !b);
      @(negedge ref_clk_in);
      r = sda_in;
    end
  endtask

  task send_byte(input [7:0] d, output nack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r);
      end
      bit_io(1'b1, nack);
    end
  endtask

  task recv_byte(input nack, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
    end
  endtask
endmodule

//--- verif/charger_config_current_regs_tb_top.sv
// testbench for the charger configuration register bank
`timescale 1ns/1ns
module charger_config_current_regs_tb_top;
  reg         ref_clk_in;
  reg         rstn_in;
  wire        scl;
  wire        pull;
  wire        sda_line;
  wire        sda_out;
  wire        sda_oe_n;
  wire        wd;
  wire [1:0]  mode;
  wire        chg_en;
  wire        bst_en;
  wire [2:0]  sysmin;
  wire [12:0] sysmin_mv;
  wire [10:0] boost_ma;
  wire [5:0]  fast_code;
  wire        force_cut;
  wire [12:0] fast_ma;
  wire [47:0] imgs;
  integer     k;
  // reset images of indices 0, 3, 4, 5, 6 and 7, first index in the top byte
  localparam [47:0] rst_imgs = 48'h3D119A9A034B;
  wire [12:0] pre_ma;
  integer     n_fail;
  integer     checks_done;
  integer     wd_pulses;
  integer     i;
  integer     n;
  reg [7:0]   rd;
  reg [7:0]   v;
  reg         ack;

  // open drain line with pull-up: low when either side pulls
  assign sda_line = !(pull || (!sda_oe_n && !sda_out));

  chc_host_model u_host (.ref_clk_in(ref_clk_in), .sda_in(sda_line), .scl_out(scl),
    .sda_pull_out(pull));

  chc_config_regs u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
    .watchdog_restart_out(wd), .charge_mode_select_out(mode), .charge_enable_out(chg_en),
    .boost_enable_out(bst_en), .min_system_voltage_out(sysmin),
    .min_system_voltage_mv_out(sysmin_mv), .boost_current_limit_ma_out(boost_ma),
    .fast_charge_current_out(fast_code), .reduced_current_force_out(force_cut),
    .fast_charge_current_ma_out(fast_ma), .precharge_current_ma_out(pre_ma),
    .input_source_control_out(imgs[47:40]), .precharge_termination_control_out(imgs[39:32]),
    .charge_voltage_control_out(imgs[31:24]), .term_timer_control_out(imgs[23:16]),
    .ir_thermal_control_out(imgs[15:8]), .misc_operation_control_out(imgs[7:0]));

  // 10 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // count restart pulses as the design drives them
  always @(posedge ref_clk_in) begin
    if (wd === 1'b1) wd_pulses <= wd_pulses + 1;
  end

  task chk(input [12:0] got, input [12:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // full write frame: address, index, data; the address and data bytes must be acknowledged
  task reg_write(input [2:0] idx, input [7:0] d);
    begin
      u_host.start;
      u_host.send_byte(8'hD6, ack);
      chk(ack, 1'b0);
      u_host.send_byte({5'h00, idx}, ack);
      u_host.send_byte(d, ack);
      chk(ack, 1'b0);
      u_host.stop;
    end
  endtask

  // index write, repeated start, one byte read ended by a host nack
  task reg_read(input [2:0] idx, output [7:0] d);
    begin
      u_host.start;
      u_host.send_byte(8'hD6, ack);
      u_host.send_byte({5'h00, idx}, ack);
      u_host.start;
      u_host.send_byte(8'hD7, ack);
      chk(ack, 1'b0);
      u_host.recv_byte(1'b1, d);
      u_host.stop;
    end
  endtask

  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  // hang guard, nearly three times the expected run
  initial begin
    #6000000;
    n_fail = n_fail + 1;
    test_done;
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    wd_pulses = 0;
    rstn_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    // power-up decode and register images
    chk(mode, 2'h1);
    chk(sysmin_mv, 13'h0DAC);
    chk(boost_ma, 11'h514);
    chk(fast_ma, 13'h0400);
    chk(pre_ma, 13'h0100);
    for (k = 0; k < 6; k = k + 1) chk(imgs[8*k +: 8], rst_imgs[8*k +: 8]);
    reg_read(3'h1, rd);
    chk(rd, 8'h1B);
    reg_read(3'h2, rd);
    chk(rd, 8'h20);
    // every mode code, voltage code and boost limit
    for (i = 0; i < 8; i = i + 1) begin
      v = {2'h0, i[1:0], i[2:0], i[0]};
      reg_write(3'h1, v);
      chk(chg_en, i[1:0] == 2'h1);
      chk(bst_en, i[1]);
      chk(sysmin, i[2:0]);
      chk(sysmin_mv, 13'h0BB8 + 13'h0064 * i[2:0]);
      chk(boost_ma, i[0] ? 11'h514 : 11'h1F4);
      reg_read(3'h1, rd);
      chk(rd, v);
    end
    // top code with force, reserved bit written as one
    reg_write(3'h2, 8'hFF);
    reg_read(3'h2, rd);
    chk(rd, 8'hFD);
    chk(fast_code, 6'h3F);
    chk(force_cut, 1'b1);
    chk(fast_ma, 13'h038C);
    chk(pre_ma, 13'h0080);
    reg_write(3'h2, 8'h00);
    chk(fast_ma, 13'h0200);
    chk(pre_ma, 13'h0100);
    // watchdog restart gives one pulse and reads back clear
    n = wd_pulses;
    reg_write(3'h1, 8'h40);
    chk(wd_pulses, n + 1);
    reg_read(3'h1, rd);
    chk(rd, 8'h00);
    // register reset restores defaults and clears itself
    reg_write(3'h2, 8'h44);
    reg_write(3'h0, 8'h55);
    reg_read(3'h0, rd);
    chk(rd, 8'h55);
    chk(imgs[47:40], 8'h55);
    reg_write(3'h1, 8'h80);
    reg_read(3'h1, rd);
    chk(rd, 8'h1B);
    reg_read(3'h2, rd);
    chk(rd, 8'h20);
    chk(fast_ma, 13'h0400);
    for (k = 0; k < 6; k = k + 1) chk(imgs[8*k +: 8], rst_imgs[8*k +: 8]);
    // foreign address and undefined index are not acknowledged
    u_host.start;
    u_host.send_byte(8'hD4, ack);
    chk(ack, 1'b1);
    u_host.stop;
    u_host.start;
    u_host.send_byte(8'hD6, ack);
    u_host.send_byte(8'h08, ack);
    chk(ack, 1'b1);
    u_host.stop;
    test_done;
  end
endmodule
